//--- design/cpu_reset_seq.sv
// reset sequencer and store-status dump engine with an Avalon-MM register slave
// -----------------------------------------------------------------------------
// Summary of operation
// - The dump writes every programmable register inside the lowest 512 bytes.
// - Timer goes to byte 216, comparator to 224 and status word to 256.
// - Floating regs go to 352, general regs to 384 and control regs to 448.
// - Power-on zeroes clock, storage, keys, registers, status word, timer, comparator.
// - Power-on reloads control storage via the microprogram load.
// - System clear zeroes storage, keys and registers but keeps the clock.
// - Control regs are initialised on power-on, clear and load, kept on system reset.
// - Program load zeroes only status word, timer and comparator.
// - System reset keeps every register and storage area for a later dump.
// - Clear, load and system reset leave control storage intact.
// - Every reset aborts the CPU operation, drops pending events and stops the CPU.
// - Every reset resets the channels, which drop operational-out.
// - System reset breaks endless interruption loops without losing state.
// -----------------------------------------------------------------------------
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_seq #(
    parameter logic [23:0] MEM_WORDS = rst_seq_pkg::MEM_WORDS_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cpu_reg_we,
    input wire logic [5:0] cpu_reg_idx,
    input wire logic [31:0] cpu_reg_wdata,
    output logic [31:0] cpu_reg_rdata,
    output logic cpu_run,
    output logic cpu_abort,
    output logic ucode_load_req,
    input wire logic ucode_load_done,
    output rst_seq_pkg::mem_req_t mem_req,
    output logic mem_we,
    input wire logic mem_wait,
    output logic chan_reset,
    output logic chan_op_out,
    output logic [63:0] time_of_day_counter
);
    // -------------------------------------------------------------------------
    // helper functions
    // -------------------------------------------------------------------------
    // what the register pass does to one word for a given reset type
    function automatic logic [1:0] word_action(input logic [1:0] rt, input logic [5:0] ix);
        logic full;
        full = (rt == rst_seq_pkg::RT_POWER_ON) || (rt == rst_seq_pkg::RT_SYS_CLEAR);
        if (rt == rst_seq_pkg::RT_SYS_RESET) begin
            word_action = rst_seq_pkg::ACT_KEEP;
        end else if (ix >= rst_seq_pkg::IX_CR) begin
            word_action = rst_seq_pkg::ACT_INIT;
        end else if (ix >= rst_seq_pkg::IX_FP) begin
            word_action = full ? rst_seq_pkg::ACT_ZERO : rst_seq_pkg::ACT_KEEP;
        end else begin
            word_action = rst_seq_pkg::ACT_ZERO;
        end
    endfunction : word_action

    // initial value of a control register
    function automatic logic [31:0] cr_init(input logic [5:0] ix);
        unique case (ix - rst_seq_pkg::IX_CR)
            6'h00: cr_init = rst_seq_pkg::CR0_INIT;
            6'h0E: cr_init = rst_seq_pkg::CR14_INIT;
            6'h0F: cr_init = rst_seq_pkg::CR15_INIT;
            default: cr_init = rst_seq_pkg::REG_RESET;
        endcase
    endfunction : cr_init

    // absolute byte address of a register word in the dump area
    function automatic logic [23:0] dump_addr(input logic [5:0] ix);
        logic [23:0] base;
        logic [5:0] first;
        if (ix >= rst_seq_pkg::IX_CR) begin
            base = rst_seq_pkg::DA_CR;
            first = rst_seq_pkg::IX_CR;
        end else if (ix >= rst_seq_pkg::IX_GR) begin
            base = rst_seq_pkg::DA_GR;
            first = rst_seq_pkg::IX_GR;
        end else if (ix >= rst_seq_pkg::IX_FP) begin
            base = rst_seq_pkg::DA_FP;
            first = rst_seq_pkg::IX_FP;
        end else if (ix >= rst_seq_pkg::IX_CSW) begin
            base = rst_seq_pkg::DA_CSW;
            first = rst_seq_pkg::IX_CSW;
        end else if (ix >= rst_seq_pkg::IX_CMP) begin
            base = rst_seq_pkg::DA_CMP;
            first = rst_seq_pkg::IX_CMP;
        end else begin
            base = rst_seq_pkg::DA_TIMER;
            first = rst_seq_pkg::IX_TIMER;
        end
        dump_addr = base + {16'h0000, ix - first, 2'h0};
    endfunction : dump_addr

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    rst_seq_pkg::seq_state_t state_reg, state_next;
    logic [31:0] regs [0:rst_seq_pkg::REG_WORDS-1];
    logic [23:0] cnt_reg, cnt_next;
    logic [1:0] type_reg;
    logic por_pend_reg, ack_reg, stopped_reg, op_out_reg;
    logic reset_done_reg, dump_done_reg;
    logic [31:0] rdata_reg;
    logic [63:0] daytime_reg;

    // bus decode
    wire logic bus_req = avs_read | avs_write;
    wire logic bus_take = bus_req & ack_reg;
    wire logic wr_ctrl = bus_take & avs_write & (avs_address == rst_seq_pkg::OFS_CTRL);
    wire logic wr_stat = bus_take & avs_write & (avs_address == rst_seq_pkg::OFS_STATUS);
    wire logic idle = (state_reg == rst_seq_pkg::S_IDLE);
    wire logic go_reset = idle & (por_pend_reg | (wr_ctrl & avs_writedata[rst_seq_pkg::CTRL_RESET_BIT]));
    wire logic go_dump = idle & ~go_reset & wr_ctrl & avs_writedata[rst_seq_pkg::CTRL_DUMP_BIT];
    wire logic go_start = idle & ~go_reset & wr_ctrl & avs_writedata[rst_seq_pkg::CTRL_START_BIT];
    wire logic [1:0] type_in = por_pend_reg ? rst_seq_pkg::RT_POWER_ON : avs_writedata[1:0];
    wire logic [5:0] ix = cnt_reg[5:0];
    wire logic [1:0] act = word_action(type_reg, ix);
    wire logic pass_regs = (state_reg == rst_seq_pkg::S_REGS);
    wire logic reg_we_seq = pass_regs & (act != rst_seq_pkg::ACT_KEEP);
    wire logic [31:0] reg_wdata_seq = (act == rst_seq_pkg::ACT_INIT) ? cr_init(ix) : rst_seq_pkg::REG_RESET;
    wire logic full_clear = (type_reg == rst_seq_pkg::RT_POWER_ON) || (type_reg == rst_seq_pkg::RT_SYS_CLEAR);
    wire logic in_dump = (state_reg == rst_seq_pkg::S_DUMP);
    wire logic in_mem = (state_reg == rst_seq_pkg::S_MEM);
    wire logic dump_end = in_dump & ~mem_wait & (ix == rst_seq_pkg::IX_LAST);
    wire logic reset_end = (pass_regs & (ix == rst_seq_pkg::IX_LAST) & ~full_clear)
        | (in_mem & ~mem_wait & (cnt_reg == MEM_WORDS - 24'h000001));

    // -------------------------------------------------------------------------
    // sequencer next state
    // -------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            rst_seq_pkg::S_IDLE: begin
                cnt_next = 24'h000000;
                if (go_reset) begin
                    state_next = rst_seq_pkg::S_HALT;
                end else if (go_dump) begin
                    state_next = rst_seq_pkg::S_DUMP;
                end
            end
            rst_seq_pkg::S_HALT: begin
                // only power-on reloads control storage
                state_next = (type_reg == rst_seq_pkg::RT_POWER_ON) ? rst_seq_pkg::S_UCODE
                    : rst_seq_pkg::S_REGS;
            end
            rst_seq_pkg::S_UCODE: begin
                if (ucode_load_done) begin
                    state_next = rst_seq_pkg::S_REGS;
                end
            end
            rst_seq_pkg::S_REGS: begin
                cnt_next = cnt_reg + 24'h000001;
                if (ix == rst_seq_pkg::IX_LAST) begin
                    cnt_next = 24'h000000;
                    state_next = full_clear ? rst_seq_pkg::S_MEM : rst_seq_pkg::S_IDLE;
                end
            end
            rst_seq_pkg::S_MEM, rst_seq_pkg::S_DUMP: begin
                if (!mem_wait) begin
                    cnt_next = cnt_reg + 24'h000001;
                    if (reset_end | dump_end) begin
                        state_next = rst_seq_pkg::S_IDLE;
                    end
                end
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // control flops
    // -------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= rst_seq_pkg::S_IDLE;
            cnt_reg <= 24'h000000;
            type_reg <= rst_seq_pkg::RT_POWER_ON;
            por_pend_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            if (go_reset) begin
                type_reg <= type_in;
                por_pend_reg <= 1'b0;
            end
        end
    end

    // cpu and channel state: every reset stops the cpu and drops operational-out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stopped_reg <= 1'b1;
            op_out_reg <= 1'b0;
        end else begin
            if (go_reset) begin
                stopped_reg <= 1'b1;
            end else if (go_start) begin
                stopped_reg <= 1'b0;
            end
            if (go_reset) begin
                op_out_reg <= 1'b0;
            end else if (reset_end) begin
                op_out_reg <= 1'b1;
            end
        end
    end

    // sticky completion flags: hardware set wins over a write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reset_done_reg <= 1'b0;
            dump_done_reg <= 1'b0;
        end else begin
            reset_done_reg <= reset_end | (reset_done_reg & ~(wr_stat & avs_writedata[rst_seq_pkg::ST_RESET_DONE]));
            dump_done_reg <= dump_end | (dump_done_reg & ~(wr_stat & avs_writedata[rst_seq_pkg::ST_DUMP_DONE]));
        end
    end

    // time-of-day counter, zeroed only by power-on
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            daytime_reg <= 64'h0000000000000000;
        end else if ((state_reg == rst_seq_pkg::S_HALT) && (type_reg == rst_seq_pkg::RT_POWER_ON)) begin
            daytime_reg <= 64'h0000000000000000;
        end else begin
            daytime_reg <= daytime_reg + 64'h0000000000000001;
        end
    end

    // programmable register file, not reset so a system reset preserves it
    always_ff @(posedge clk) begin
        if (reg_we_seq) begin
            regs[ix] <= reg_wdata_seq;
        end else if (cpu_reg_we && idle && !stopped_reg && (cpu_reg_idx <= rst_seq_pkg::IX_LAST)) begin
            regs[cpu_reg_idx] <= cpu_reg_wdata;
        end
        cpu_reg_rdata <= (cpu_reg_idx <= rst_seq_pkg::IX_LAST) ? regs[cpu_reg_idx] : rst_seq_pkg::REG_RESET;
    end

    // -------------------------------------------------------------------------
    // bus slave: one wait cycle, registered read data
    // -------------------------------------------------------------------------
    wire logic [31:0] status_word = {27'h0, dump_done_reg, reset_done_reg, op_out_reg, stopped_reg, ~idle};
    wire logic [31:0] rd_mux = (avs_address == rst_seq_pkg::OFS_CTRL) ? {30'h0, type_reg}
        : (avs_address == rst_seq_pkg::OFS_STATUS) ? status_word
        : (avs_address == rst_seq_pkg::OFS_TIME_LO) ? daytime_reg[31:0]
        : (avs_address == rst_seq_pkg::OFS_TIME_HI) ? daytime_reg[63:32] : 32'h00000000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req && !ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign avs_readdata = rdata_reg;
    assign cpu_run = ~stopped_reg;
    assign cpu_abort = (state_reg == rst_seq_pkg::S_HALT);
    assign chan_reset = (state_reg == rst_seq_pkg::S_HALT);
    assign chan_op_out = op_out_reg;
    assign ucode_load_req = (state_reg == rst_seq_pkg::S_UCODE);
    assign time_of_day_counter = daytime_reg;
    // storage writes: zero fill with key clear, or big-endian dump word
    assign mem_we = in_mem | in_dump;
    assign mem_req.addr = in_dump ? dump_addr(ix) : {cnt_reg[21:0], 2'h0};
    assign mem_req.data = in_dump ? regs[ix] : rst_seq_pkg::REG_RESET;
    assign mem_req.key_clr = in_mem;

    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    property p_dump_range;
        @(posedge clk) disable iff (sys_rst) in_dump |-> mem_req.addr + 24'h000004 <= rst_seq_pkg::DUMP_LIMIT;
    endproperty
    a_dump_range: assert property (p_dump_range) else $error("dump outside low area");

    property p_dump_first;
        @(posedge clk) disable iff (sys_rst) idle && go_dump |=> mem_we && mem_req.addr == rst_seq_pkg::DA_TIMER;
    endproperty
    a_dump_first: assert property (p_dump_first) else $error("dump does not start at timer");

    property p_dump_fp;
        @(posedge clk) disable iff (sys_rst) in_dump && ix == rst_seq_pkg::IX_FP |-> mem_req.addr == 24'h000160;
    endproperty
    a_dump_fp: assert property (p_dump_fp) else $error("floating regs misplaced");

    property p_ucode;
        @(posedge clk) disable iff (sys_rst) state_reg == rst_seq_pkg::S_HALT
            |=> ucode_load_req == ($past(type_reg) == rst_seq_pkg::RT_POWER_ON);
    endproperty
    a_ucode: assert property (p_ucode) else $error("microprogram load misuse");

    property p_time_kept;
        @(posedge clk) disable iff (sys_rst) type_reg != rst_seq_pkg::RT_POWER_ON && !idle
            |=> daytime_reg == $past(daytime_reg) + 64'h0000000000000001;
    endproperty
    a_time_kept: assert property (p_time_kept) else $error("clock disturbed");
    property p_cr_init;
        @(posedge clk) disable iff (sys_rst) pass_regs && type_reg != rst_seq_pkg::RT_SYS_RESET
            && ix >= rst_seq_pkg::IX_CR |-> reg_we_seq && reg_wdata_seq == cr_init(ix);
    endproperty
    a_cr_init: assert property (p_cr_init) else $error("control register not initialised");
    property p_load_keep;
        @(posedge clk) disable iff (sys_rst) pass_regs && type_reg == rst_seq_pkg::RT_LOAD
            |-> reg_we_seq == (ix < rst_seq_pkg::IX_FP || ix >= rst_seq_pkg::IX_CR);
    endproperty
    a_load_keep: assert property (p_load_keep) else $error("load touched kept state");
    property p_sysrst_keep;
        @(posedge clk) disable iff (sys_rst) type_reg == rst_seq_pkg::RT_SYS_RESET |-> !reg_we_seq && !in_mem;
    endproperty
    a_sysrst_keep: assert property (p_sysrst_keep) else $error("system reset changed state");
    property p_halt;
        @(posedge clk) disable iff (sys_rst) go_reset |=> chan_reset && cpu_abort && !chan_op_out && !cpu_run;
    endproperty
    a_halt: assert property (p_halt) else $error("reset did not stop cpu and channels");
    property p_dump_done;
        @(posedge clk) disable iff (sys_rst) dump_end |=> idle && dump_done_reg && !mem_we;
    endproperty
    a_dump_done: assert property (p_dump_done) else $error("dump completion wrong");
endmodule : cpu_reset_seq
`default_nettype wire

//--- design/rst_seq_pkg.sv
// constants, types and layout shared by the reset and status-dump sequencer
package rst_seq_pkg;
    // reset types as coded in the control register
    localparam logic [1:0] RT_POWER_ON = 2'h0;
    localparam logic [1:0] RT_SYS_CLEAR = 2'h1;
    localparam logic [1:0] RT_LOAD = 2'h2;
    localparam logic [1:0] RT_SYS_RESET = 2'h3;
    // word index of each register group in the programmable register file
    localparam logic [5:0] IX_TIMER = 6'h00;
    localparam logic [5:0] IX_CMP = 6'h02;
    localparam logic [5:0] IX_CSW = 6'h04;
    localparam logic [5:0] IX_FP = 6'h06;
    localparam logic [5:0] IX_GR = 6'h0E;
    localparam logic [5:0] IX_CR = 6'h1E;
    localparam logic [5:0] IX_LAST = 6'h2D;
    localparam int REG_WORDS = 46;
    // absolute byte address of the first byte of each group in the dump
    localparam logic [23:0] DA_TIMER = 24'h0000D8;
    localparam logic [23:0] DA_CMP = 24'h0000E0;
    localparam logic [23:0] DA_CSW = 24'h000100;
    localparam logic [23:0] DA_FP = 24'h000160;
    localparam logic [23:0] DA_GR = 24'h000180;
    localparam logic [23:0] DA_CR = 24'h0001C0;
    localparam logic [23:0] DUMP_LIMIT = 24'h000200;
    // bus register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_TIME_LO = 4'h8;
    localparam logic [3:0] OFS_TIME_HI = 4'hC;
    // control register fields
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_RESET_BIT = 2;
    localparam int CTRL_DUMP_BIT = 3;
    localparam int CTRL_START_BIT = 4;
    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_STOPPED = 1;
    localparam int ST_OPOUT = 2;
    localparam int ST_RESET_DONE = 3;
    localparam int ST_DUMP_DONE = 4;
    // initial state of the control registers (plain defaults)
    localparam logic [31:0] CR0_INIT = 32'h00000000;
    localparam logic [31:0] CR14_INIT = 32'h00000000;
    localparam logic [31:0] CR15_INIT = 32'h00000000;
    localparam logic [31:0] REG_RESET = 32'h00000000;
    localparam logic [23:0] MEM_WORDS_DEFAULT = 24'h000400;
    // per-word action during the register pass
    localparam logic [1:0] ACT_KEEP = 2'h0;
    localparam logic [1:0] ACT_ZERO = 2'h1;
    localparam logic [1:0] ACT_INIT = 2'h2;

    typedef enum logic [2:0] {S_IDLE, S_HALT, S_UCODE, S_REGS, S_MEM, S_DUMP} seq_state_t;

    // one word write toward processor storage
    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] data;
        logic key_clr;
    } mem_req_t;
endpackage : rst_seq_pkg

//--- dv/seq_partner.sv
// storage, console and channel partner model for the reset sequencer bench
`timescale 1ns/1ps
`default_nettype none
module seq_partner (
    input wire logic clk,
    input wire rst_seq_pkg::mem_req_t mem_req,
    input wire logic mem_we,
    output logic mem_wait,
    input wire logic stall,
    input wire logic ucode_load_req,
    output logic ucode_load_done,
    input wire logic chan_reset
);
    logic [31:0] mem [0:127];
    logic [1:0] ucode_cnt = 2'h0;
    logic req_q = 1'b0;
    int ucode_reqs = 0;
    int chan_resets = 0;
    int key_clrs = 0;
    // storage back-pressure comes straight from the bench's random stall line
    assign mem_wait = stall;
    // storage takes a word on each edge with no stall; loader answers after four cycles
    always @(posedge clk) begin
        if (mem_we && !mem_wait && mem_req.addr < 24'h000200) mem[mem_req.addr[8:2]] <= mem_req.data;
        if (mem_we && !mem_wait && mem_req.key_clr) key_clrs <= key_clrs + 1;
        ucode_cnt <= ucode_load_req ? ucode_cnt + 2'h1 : 2'h0;
        ucode_load_done <= ucode_load_req && ucode_cnt == 2'h3;
        // count each load request once, on its rising edge
        req_q <= ucode_load_req;
        if (ucode_load_req && !req_q) ucode_reqs <= ucode_reqs + 1;
        if (chan_reset) chan_resets <= chan_resets + 1;
    end
endmodule : seq_partner
`default_nettype wire

//--- dv/cpu_reset_seq_test.sv
// self-checking bench for the reset sequencer and store-status dump engine
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_seq_test;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, cpu_reg_wdata = 32'h0, cpu_reg_rdata, rd, time0;
    logic cpu_reg_we = 1'b0, cpu_run, cpu_abort, ucode_load_req, ucode_load_done, mem_we, mem_wait;
    logic chan_reset, chan_op_out, stall = 1'b0;
    logic [5:0] cpu_reg_idx = 6'h00;
    logic [63:0] time_of_day_counter;
    rst_seq_pkg::mem_req_t mem_req;
    logic [31:0] shadow [0:45];
    int seed = 44267, miscompares = 0, compares = 0, cycles = 0, aborts = 0, aborts0, resets;
    cpu_reset_seq #(.MEM_WORDS(24'h000010)) i_cpu_reset_seq (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_reg_we(cpu_reg_we),
        .cpu_reg_idx(cpu_reg_idx), .cpu_reg_wdata(cpu_reg_wdata), .cpu_reg_rdata(cpu_reg_rdata),
        .cpu_run(cpu_run), .cpu_abort(cpu_abort), .ucode_load_req(ucode_load_req),
        .ucode_load_done(ucode_load_done), .mem_req(mem_req), .mem_we(mem_we), .mem_wait(mem_wait),
        .chan_reset(chan_reset), .chan_op_out(chan_op_out), .time_of_day_counter(time_of_day_counter));
    seq_partner i_seq_partner (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_wait(mem_wait),
        .stall(stall), .ucode_load_req(ucode_load_req), .ucode_load_done(ucode_load_done),
        .chan_reset(chan_reset));
    // --------------------------------------------------------------------
    // clock, random storage stall, abort counting and timeout
    // --------------------------------------------------------------------
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        stall <= ($random(seed) & 3) == 0;
        if (cpu_abort === 1'b1) aborts <= aborts + 1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end
    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares = compares + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one Avalon access, held until waitrequest is sampled low at a rising edge; data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wait_idle();
        int n;
        for (n = 0; n < 300; n++) begin
            bus(1'b0, rst_seq_pkg::OFS_STATUS, 32'h0, rd);
            if (rd[rst_seq_pkg::ST_BUSY] === 1'b0) break;
        end
    endtask : wait_idle
    function automatic logic [8:0] dump_addr(input int i);
        if (i < 2) return 9'd216 + 9'(4 * i);
        if (i < 4) return 9'd224 + 9'(4 * (i - 2));
        if (i < 6) return 9'd256 + 9'(4 * (i - 4));
        if (i < 14) return 9'd352 + 9'(4 * (i - 6));
        if (i < 30) return 9'd384 + 9'(4 * (i - 14));
        return 9'd448 + 9'(4 * (i - 30));
    endfunction : dump_addr
    // register word expected after a reset of type t
    function automatic logic [31:0] exp_reg(input int t, input int i);
        if (t == 3) return shadow[i];
        if (i == 30) return rst_seq_pkg::CR0_INIT;
        if (i == 44) return rst_seq_pkg::CR14_INIT;
        if (i == 45) return rst_seq_pkg::CR15_INIT;
        if (i > 30) return rst_seq_pkg::REG_RESET;
        if (i < 6 || t < 2) return 32'h00000000;
        return shadow[i];
    endfunction : exp_reg
    task automatic fill();
        for (int i = 0; i < 128; i++) i_seq_partner.mem[i] = 32'h5A5A0000 ^ i;
    endtask : fill
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        int t;
        fill();
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        wait_idle();
        for (int i = 0; i < 16; i++) chk("poweron_mem", 32'h0, i_seq_partner.mem[i]);
        chk("ucode_reqs", 32'h1, 32'(i_seq_partner.ucode_reqs));
        chk("poweron_keys", 32'h10, 32'(i_seq_partner.key_clrs));
        chk("status", 32'h0000000E, rd);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        for (int k = 0; k < 4; k++) begin
            t = 3 - k;
            bus(1'b1, rst_seq_pkg::OFS_CTRL, 32'h10, rd);
            @(negedge clk);
            chk("cpu_run", 32'h1, 32'(cpu_run));
            for (int i = 0; i < 46; i++) begin
                shadow[i] = (i == 0) ? 32'hFFFFFFFF : $random(seed);
                @(posedge clk);
                cpu_reg_we <= 1'b1;
                cpu_reg_idx <= 6'(i);
                cpu_reg_wdata <= shadow[i];
            end
            @(posedge clk);
            cpu_reg_we <= 1'b0;
            fill();
            resets = i_seq_partner.chan_resets;
            aborts0 = aborts;
            bus(1'b0, rst_seq_pkg::OFS_TIME_LO, 32'h0, time0);
            bus(1'b1, rst_seq_pkg::OFS_CTRL, 32'(t) | 32'h4, rd);
            wait_idle();
            bus(1'b0, rst_seq_pkg::OFS_TIME_LO, 32'h0, rd);
            if (t == 0) chk("time_cleared", 32'h1, 32'(rd < time0));
            else chk("time_kept", 32'h1, 32'(rd > time0));
            @(negedge clk);
            chk("time_port", rd + 32'h00000002, time_of_day_counter[31:0]);
            chk("ucode_loads", 32'(1 + (t == 0)), 32'(i_seq_partner.ucode_reqs));
            chk("stopped", 32'h0, 32'(cpu_run));
            chk("aborts", 32'h1, 32'(aborts - aborts0));
            chk("op_out", 32'h1, 32'(chan_op_out));
            chk("chan_resets", 32'(resets + 1), 32'(i_seq_partner.chan_resets));
            for (int i = 0; i < 16; i++)
                chk("storage", (t < 2) ? 32'h0 : 32'h5A5A0000 ^ i, i_seq_partner.mem[i]);
            bus(1'b0, rst_seq_pkg::OFS_CTRL, 32'h0, rd);
            chk("ctrl_type", 32'(t), rd);
            bus(1'b1, rst_seq_pkg::OFS_CTRL, 32'h8, rd);
            wait_idle();
            chk("dump_done", 32'h1, 32'(rd[rst_seq_pkg::ST_DUMP_DONE]));
            for (int i = 0; i < 46; i++)
                chk("dump_word", exp_reg(t, i), i_seq_partner.mem[dump_addr(i) >> 2]);
            chk("key_clears", 32'(16 * (1 + (t < 2) + (t == 0))), 32'(i_seq_partner.key_clrs));
            cpu_reg_idx <= 6'h14;
            @(negedge clk);
            @(negedge clk);
            chk("cpu_reg_rdata", exp_reg(t, 20), cpu_reg_rdata);
            bus(1'b1, rst_seq_pkg::OFS_STATUS, 32'h18, rd);
            bus(1'b0, rst_seq_pkg::OFS_STATUS, 32'h0, rd);
            chk("status_w1c", 32'h00000006, rd);
        end
        test_done();
    end
endmodule : cpu_reset_seq_test
`default_nettype wire
